//--- acr_top.sv
// Top of the converter control and readout block with its Avalon-MM register slave.
//
// Contract
// R1: A running conversion is never restarted nor aborted.
// R2: Low-power rate: held-low start self-restarts conversions.
// R3: Host pulses start low once after power-up.
// R4: Self-restart only in the low-power rate.
// R5: Outputs drive only when select and read low.
// R6: Result coded twos complement or straight binary.
// R7: Parallel bus when serial select is low.
// R8: Host finishes in-conversion reads in first half.
// R9: Byte swap exchanges the two result byte lanes.
// R10: Serial output is 16 bits, MSB first.
// R11: Serial bit valid on both clock edges.
// R12: Master mode drives serial clock and frame strobe.
// R13: Master clock and frame strobe polarity selectable.
// R14: Read mode pin picks after or during conversion.
// R15: Master read-after keeps busy until 16 bits out.
// R16: Slave mode shifts on the host serial clock.
// R17: Slave clock gated by select and read low.
// R18: Slave accepts continuous or idle-high/low clock.
// R19: Host clock idles during second half of busy.
// R20: Unfinished in-conversion slave read pulses overrun flag.
// R21: Busy high from conversion start to completion.
module acr_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Avalon-MM register slave
  input wire logic [acr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Conversion control pins
  input wire logic convert_start_n,
  input wire logic power_down_input,
  output logic busy,
  // Interface selection pins
  input wire logic device_select_n,
  input wire logic read_enable_n,
  input wire logic output_coding_select,
  input wire logic serial_parallel_select,
  input wire logic byte_order_swap,
  input wire logic clock_source_select,
  input wire logic read_mode_or_chain_input,
  // Parallel data bus
  output logic [acr_pkg::RES_W-1:0] data_out,
  output logic data_oe,
  // Serial port
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic frame_valid_strobe,
  output logic frame_valid_oe,
  output logic read_overrun_flag
);
  import acr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int PIN_N = 10;
  localparam int P_CONVERT_START_N = 0;
  localparam int P_PD = 1;
  localparam int P_CS = 2;
  localparam int P_RD = 3;
  localparam int P_CODE = 4;
  localparam int P_SER = 5;
  localparam int P_SWAP = 6;
  localparam int P_EXT = 7;
  localparam int P_RDC = 8;
  localparam int P_SCLK = 9;

  typedef struct packed {
    logic [PIN_N-1:0] meta;
    logic [PIN_N-1:0] pins;
    logic sclk_prev;
    logic [1:0] rate;
    logic sclk_inv;
    logic sync_inv;
    logic [RES_W-1:0] sample;
    logic go_rac;
    logic waitreq;
    logic [31:0] rdata;
    logic busy;
    logic [RES_W-1:0] dout;
    logic doe;
    logic sclk_o;
    logic sclk_oe;
    logic sdo;
    logic sdo_oe;
    logic fvs;
    logic fvs_oe;
    logic overrun;
  } acr_top_t;

  acr_top_t tp_reg;
  acr_top_t tp_next;

  acr_core_if core ();

  logic [PIN_N-1:0] pin_raw;
  logic selected;
  logic master_mode;
  logic req;
  logic commit;
  logic [31:0] rd_word;

  assign pin_raw = {serial_clock_in, read_mode_or_chain_input, clock_source_select, byte_order_swap,
                    serial_parallel_select, output_coding_select, read_enable_n, device_select_n,
                    power_down_input, convert_start_n};

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  acr_conv u_conv (
    .clock(clock),
    .reset_n(reset_n),
    .core(core.conv)
  );

  acr_ser u_ser (
    .clock(clock),
    .reset_n(reset_n),
    .core(core.ser)
  );

  // ----------------------------------------------------------------
  // Core drive
  // ----------------------------------------------------------------
  // Chip select and read are OR'd: either one high disables all four output enables (parallel, serial data, serial clock, strobe).
  assign selected = ~tp_reg.pins[P_CS] & ~tp_reg.pins[P_RD]; // R5
  assign master_mode = tp_reg.pins[P_SER] & ~tp_reg.pins[P_EXT]; // R12
  assign core.convert_start_n_n = tp_reg.pins[P_CONVERT_START_N];
  assign core.pd = tp_reg.pins[P_PD];
  assign core.rate = tp_reg.rate;
  assign core.coding = tp_reg.pins[P_CODE]; // R6
  assign core.sample = tp_reg.sample;
  // Busy is stretched only for a master read after conversion.
  assign core.hold_en = master_mode & ~tp_reg.pins[P_RDC]; // R15 R14
  assign core.load = core.done;
  assign core.master = master_mode;
  // Read during conversion shifts the previous result from the start of the next one.
  assign core.go = tp_reg.pins[P_RDC] ? core.start : tp_reg.go_rac; // R14
  // The slave clock only counts while the part is selected and read is low.
  assign core.step = tp_reg.pins[P_SER] & tp_reg.pins[P_EXT] & selected
                     & tp_reg.pins[P_SCLK] & ~tp_reg.sclk_prev; // R17 R18

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign req = avs_read | avs_write;
  assign commit = avs_write & ~tp_reg.waitreq;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      ADDR_CTRL: begin
        rd_word[CTRL_RATE_LSB +: 2] = tp_reg.rate;
        rd_word[CTRL_SCLK_INV] = tp_reg.sclk_inv;
        rd_word[CTRL_SYNC_INV] = tp_reg.sync_inv;
      end
      ADDR_SAMPLE: begin
        rd_word[RES_W-1:0] = tp_reg.sample;
      end
      ADDR_STATUS: begin
        rd_word[STAT_BUSY] = core.busy;
        rd_word[STAT_ALL_READ] = core.all_read;
        rd_word[STAT_MASTER_ACTIVE] = core.sync;
      end
      ADDR_RESULT: begin
        rd_word[RES_W-1:0] = core.result;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    tp_next = tp_reg;
    // Two flops per pin; only the second stage feeds logic.
    tp_next.meta = pin_raw;
    tp_next.pins = tp_reg.meta;
    tp_next.sclk_prev = tp_reg.pins[P_SCLK];
    tp_next.go_rac = core.done & ~tp_reg.pins[P_RDC];

    // One wait cycle, then one ready cycle; the master releases after the ready edge.
    if (req && tp_reg.waitreq) begin
      tp_next.waitreq = 1'b0;
      tp_next.rdata = rd_word;
    end else begin
      tp_next.waitreq = 1'b1;
    end
    if (commit) begin
      case (avs_address)
        ADDR_CTRL: begin
          tp_next.rate = avs_writedata[CTRL_RATE_LSB +: 2];
          tp_next.sclk_inv = avs_writedata[CTRL_SCLK_INV];
          tp_next.sync_inv = avs_writedata[CTRL_SYNC_INV];
        end
        ADDR_SAMPLE: begin
          tp_next.sample = avs_writedata[RES_W-1:0];
        end
        default: begin
          tp_next.sample = tp_reg.sample;
        end
      endcase
    end

    tp_next.busy = core.busy; // R21
    tp_next.doe = selected & ~tp_reg.pins[P_SER]; // R5 R7
    tp_next.dout = tp_reg.pins[P_SWAP] ? {core.result[7:0], core.result[15:8]} : core.result; // R9
    tp_next.sdo_oe = selected & tp_reg.pins[P_SER]; // R5 R10
    tp_next.sdo = core.sdo;
    tp_next.sclk_oe = selected & master_mode; // R12
    tp_next.sclk_o = core.sclk ^ tp_reg.sclk_inv; // R13
    tp_next.fvs_oe = selected & master_mode;
    tp_next.fvs = core.sync ^ tp_reg.sync_inv; // R13
    // A slave read during conversion that missed bits is flagged as the result is replaced.
    tp_next.overrun = core.done & tp_reg.pins[P_SER] & tp_reg.pins[P_EXT]
                      & tp_reg.pins[P_RDC] & ~core.all_read; // R20
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tp_reg <= '{meta: 10'h3ff, pins: 10'h3ff, sclk_prev: 1'b1, rate: CTRL_RESET[1:0],
                  sclk_inv: CTRL_RESET[CTRL_SCLK_INV], sync_inv: CTRL_RESET[CTRL_SYNC_INV],
                  sample: SAMPLE_RESET, go_rac: 1'b0, waitreq: 1'b1, rdata: 32'h0000_0000,
                  busy: 1'b0, dout: 16'h0000, doe: 1'b0, sclk_o: 1'b0, sclk_oe: 1'b0, sdo: 1'b0,
                  sdo_oe: 1'b0, fvs: 1'b0, fvs_oe: 1'b0, overrun: 1'b0};
    end else begin
      tp_reg <= tp_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = tp_reg.rdata;
  assign avs_waitrequest = tp_reg.waitreq;
  assign busy = tp_reg.busy;
  assign data_out = tp_reg.dout;
  assign data_oe = tp_reg.doe;
  assign serial_clock_out = tp_reg.sclk_o;
  assign serial_clock_oe = tp_reg.sclk_oe;
  assign serial_data_out = tp_reg.sdo;
  assign serial_data_oe = tp_reg.sdo_oe;
  assign frame_valid_strobe = tp_reg.fvs;
  assign frame_valid_oe = tp_reg.fvs_oe;
  assign read_overrun_flag = tp_reg.overrun;

endmodule // acr_top

//--- acr_pkg.sv
// Shared constants and types for the converter control and readout block.
package acr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  // Long enough that a whole master frame fits inside one conversion.
  localparam int CONV_TIME_NS = 2000;
  localparam int ACQ_TIME_NS = 500;
  localparam int MSCLK_HALF_NS = 50;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_CNT = CNT_W'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ACQ_CNT = CNT_W'((ACQ_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] MSCLK_HALF_CNT = CNT_W'((MSCLK_HALF_NS * CLK_MHZ) / 1000);

  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int RES_W = 16;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] RES_BITS = 5'h10;

  // ----------------------------------------------------------------
  // Conversion rate modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_FAST = 2'h0;
  localparam logic [1:0] RATE_STD = 2'h1;
  localparam logic [1:0] RATE_LOW = 2'h2;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'hc;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_SCLK_INV = 2;
  localparam int CTRL_SYNC_INV = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ALL_READ = 1;
  localparam int STAT_MASTER_ACTIVE = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [RES_W-1:0] SAMPLE_RESET = 16'h0000;

endpackage

//--- acr_core_if.sv
// Signals shared between the top, the conversion sequencer and the serial shifter.
interface acr_core_if;
  import acr_pkg::*;

  logic convert_start_n_n;
  logic pd;
  logic [1:0] rate;
  logic coding;
  logic hold_en;
  logic [RES_W-1:0] sample;
  logic busy;
  logic done;
  logic start;
  logic [RES_W-1:0] result;
  logic load;
  logic master;
  logic go;
  logic step;
  logic sdo;
  logic sclk;
  logic sync;
  logic ser_done;
  logic all_read;

  modport conv (input convert_start_n_n, pd, rate, coding, hold_en, sample, ser_done,
                output busy, done, start, result);
  modport ser (input load, result, master, go, step,
               output sdo, sclk, sync, ser_done, all_read);
  modport top (output convert_start_n_n, pd, rate, coding, hold_en, sample, load, master, go, step,
               input busy, done, start, result, sdo, sclk, sync, ser_done, all_read);
endinterface

//--- acr_conv.sv
// Conversion sequencer: start, busy timing, automatic restart and result coding.
module acr_conv (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Core signals
  acr_core_if.conv core
);
  import acr_pkg::*;

  typedef enum logic [1:0] {CV_IDLE, CV_CONVERT, CV_HOLD, CV_ACQUIRE} acr_cv_state_t;

  typedef struct packed {
    acr_cv_state_t state;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
    logic start;
    logic cnv_prev;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] result;
  } acr_cv_t;

  acr_cv_t cv_reg;
  acr_cv_t cv_next;
  logic auto_go;
  logic cnv_fall;

  assign core.busy = cv_reg.busy;
  assign core.done = cv_reg.done;
  assign core.start = cv_reg.start;
  assign core.result = cv_reg.result;

  always_comb begin
    cv_next = cv_reg;
    cv_next.done = 1'b0;
    cv_next.start = 1'b0;
    cv_next.cnv_prev = core.convert_start_n_n;
    cnv_fall = cv_reg.cnv_prev & ~core.convert_start_n_n;
    // Self-running restart exists only in the low-power rate.
    auto_go = (core.rate == RATE_LOW) & ~core.convert_start_n_n; // R2 R4
    case (cv_reg.state)
      CV_IDLE: begin
        if ((cnv_fall | auto_go) & ~core.pd) begin
          cv_next.state = CV_CONVERT;
          cv_next.cnt = '0;
          cv_next.busy = 1'b1; // R21
          cv_next.start = 1'b1;
          cv_next.sample = core.sample;
        end
      end
      CV_CONVERT: begin
        // Neither a new start edge nor power-down is looked at here.
        if (cv_reg.cnt == CONV_CNT - 8'h01) begin // R1
          cv_next.done = 1'b1;
          // Unipolar code: twos complement is straight binary with the top bit flipped.
          cv_next.result = core.coding ? cv_reg.sample : {~cv_reg.sample[RES_W-1], cv_reg.sample[RES_W-2:0]}; // R6
          if (core.hold_en) begin
            cv_next.state = CV_HOLD; // R15
          end else begin
            cv_next.busy = 1'b0; // R21
            cv_next.cnt = '0;
            cv_next.state = auto_go ? CV_ACQUIRE : CV_IDLE; // R2
          end
        end else begin
          cv_next.cnt = cv_reg.cnt + 8'h01;
        end
      end
      CV_HOLD: begin
        if (core.ser_done) begin
          cv_next.busy = 1'b0; // R15
          cv_next.cnt = '0;
          cv_next.state = auto_go ? CV_ACQUIRE : CV_IDLE;
        end
      end
      CV_ACQUIRE: begin
        if (~auto_go | core.pd) begin
          cv_next.state = CV_IDLE;
        end else if (cv_reg.cnt == ACQ_CNT - 8'h01) begin
          cv_next.state = CV_CONVERT; // R2
          cv_next.cnt = '0;
          cv_next.busy = 1'b1;
          cv_next.start = 1'b1;
          cv_next.sample = core.sample;
        end else begin
          cv_next.cnt = cv_reg.cnt + 8'h01;
        end
      end
      default: begin
        cv_next.state = CV_IDLE;
        cv_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cv_reg <= '{state: CV_IDLE, cnt: '0, busy: 1'b0, done: 1'b0, start: 1'b0,
                  cnv_prev: 1'b1, sample: '0, result: '0};
    end else begin
      cv_reg <= cv_next;
    end
  end

endmodule // acr_conv

//--- acr_ser.sv
// Serial result shifter for master (own clock) and slave (host clock) readout.
module acr_ser (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Core signals
  acr_core_if.ser core
);
  import acr_pkg::*;

  typedef struct packed {
    logic [RES_W-1:0] shreg;
    logic [BIT_CNT_W-1:0] bits;
    logic [CNT_W-1:0] div;
    logic active;
    logic sclk;
    logic sync;
    logic done;
  } acr_ser_t;

  acr_ser_t sr_reg;
  acr_ser_t sr_next;

  assign core.sdo = sr_reg.shreg[RES_W-1];
  assign core.sclk = sr_reg.sclk;
  assign core.sync = sr_reg.sync;
  assign core.ser_done = sr_reg.done;
  assign core.all_read = (sr_reg.bits == RES_BITS);

  always_comb begin
    sr_next = sr_reg;
    sr_next.done = 1'b0;
    if (core.load) begin
      sr_next.shreg = core.result; // R10
      sr_next.bits = '0;
      sr_next.active = 1'b0;
      sr_next.sclk = 1'b0;
      sr_next.sync = 1'b0;
    end else if (core.master) begin
      if (core.go && !sr_reg.active) begin
        // Reload, so a frame during conversion carries the last result even after an earlier read.
        sr_next.shreg = core.result; // R14
        sr_next.bits = '0;
        sr_next.active = 1'b1;
        sr_next.sync = 1'b1; // R12
        sr_next.div = '0;
      end else if (sr_reg.active) begin
        if (sr_reg.div == MSCLK_HALF_CNT - 8'h01) begin
          sr_next.div = '0;
          sr_next.sclk = ~sr_reg.sclk; // R12
          // Data moves on the falling edge so it is stable around the rising one.
          if (sr_reg.sclk) begin // R11
            sr_next.shreg = {sr_reg.shreg[RES_W-2:0], 1'b0};
            sr_next.bits = sr_reg.bits + 5'h01;
            if (sr_reg.bits == RES_BITS - 5'h01) begin
              sr_next.active = 1'b0;
              sr_next.sync = 1'b0;
              sr_next.done = 1'b1; // R15
            end
          end
        end else begin
          sr_next.div = sr_reg.div + 8'h01;
        end
      end
    end else if (core.step && sr_reg.bits != RES_BITS) begin
      // The host's rising edge moves to the next bit, which then holds a full period.
      sr_next.shreg = {sr_reg.shreg[RES_W-2:0], 1'b0}; // R16 R11
      sr_next.bits = sr_reg.bits + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sr_reg <= '{shreg: '0, bits: 5'h10, div: '0, active: 1'b0, sclk: 1'b0, sync: 1'b0, done: 1'b0};
    end else begin
      sr_reg <= sr_next;
    end
  end

endmodule // acr_ser

//--- acr_top_asserts.sv
// Port checker for the converter control and readout block.
module acr_top_asserts
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Observed ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic busy,
  input wire logic device_select_n,
  input wire logic read_enable_n,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic read_mode_or_chain_input,
  input wire logic data_oe,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic serial_data_oe,
  input wire logic frame_valid_oe,
  input wire logic read_overrun_flag
);
  logic [7:0] busy_cnt;
  logic [2:0] off_cnt;
  logic [2:0] ext_cnt;
  logic rd_after_master;

  // Pins cross a synchroniser, so a level is trusted only once it has stood five cycles.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy_cnt <= 8'h00;
      off_cnt <= 3'h0;
      ext_cnt <= 3'h0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;
      off_cnt <= (device_select_n | read_enable_n) ? off_cnt + {2'h0, off_cnt != 3'h5} : 3'h0;
      ext_cnt <= clock_source_select ? ext_cnt + {2'h0, ext_cnt != 3'h5} : 3'h0;
    end
  end
  assign rd_after_master = serial_parallel_select & !clock_source_select & !read_mode_or_chain_input;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ----
  // Properties
  // ----
  req_answer_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  busy_min_a: assert property ($fell(busy) |-> busy_cnt >= CONV_CNT)
    else $error("busy dropped before the conversion time");
  busy_len_a: assert property ($fell(busy) && !rd_after_master |-> busy_cnt == CONV_CNT)
    else $error("busy width differs from the conversion time");
  out_gate_a: assert property (off_cnt == 3'h5 |-> !data_oe && !serial_data_oe)
    else $error("outputs driven while deselected");
  ext_clk_a: assert property (ext_cnt == 3'h5 |-> !serial_clock_oe && !frame_valid_oe)
    else $error("serial clock or strobe driven in slave mode");
  ovr_pulse_a: assert property (read_overrun_flag |=> !read_overrun_flag)
    else $error("overrun flag longer than one cycle");
  ovr_mode_a: assert property (read_overrun_flag |->
    serial_parallel_select && clock_source_select && read_mode_or_chain_input)
    else $error("overrun flag outside slave read-during mode");
  sclk_half_a: assert property (serial_clock_oe && $past(serial_clock_oe) && $changed(serial_clock_out)
    |=> $stable(serial_clock_out))
    else $error("master serial clock half period too short");

  cover property ($fell(busy));
  cover property (read_overrun_flag);
  cover property (serial_clock_oe && frame_valid_oe && $changed(serial_clock_out));
endmodule // acr_top_asserts

bind acr_top acr_top_asserts u_acr_chk (.clock, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .busy,
  .device_select_n, .read_enable_n, .serial_parallel_select, .clock_source_select, .read_mode_or_chain_input,
  .data_oe, .serial_clock_out, .serial_clock_oe, .serial_data_oe, .frame_valid_oe, .read_overrun_flag);

//--- acr_host_model.sv
// Host model that clocks or follows the serial port and collects a result word.
module acr_host_model (
  // Clock and bench control
  input wire logic clock,
  input wire logic go,
  input wire logic idle_hi,
  input wire logic master,
  input wire logic inv,
  // Device serial pins
  input wire logic sdo,
  input wire logic sclk_dev,
  input wire logic sync_dev,
  // Host clock and captured word
  output logic sclk,
  output logic [15:0] word,
  output logic [4:0] nbits,
  output logic edge_err
);
  int ph = 0;
  logic prev = 1'b0;

  initial begin
    sclk = 1'b0;
    word = 16'h0000;
    nbits = 5'h00;
    edge_err = 1'b0;
  end

  always @(posedge clock) begin
    prev <= sclk_dev;
    if (go) begin
      ph <= master ? 0 : 1;
      nbits <= 5'h00;
      edge_err <= 1'b0;
    end else if (ph != 0) begin
      // Sixteen host periods, then the clock stands still at its idle level.
      ph <= (ph == 128) ? 0 : ph + 1;
      if ((ph - 1) % 8 == 3) begin
        word <= {word[14:0], sdo};
        nbits <= nbits + 5'h01;
      end
      if ((ph - 1) % 8 == 5 && sdo !== word[0]) begin
        edge_err <= 1'b1;
      end
    end else if (master && sclk_dev != prev && (sclk_dev ^ inv) && (sync_dev ^ inv)) begin
      word <= {word[14:0], sdo};
      nbits <= nbits + 5'h01;
    end
  end

  always @(posedge clock) begin
    sclk <= (ph != 0) ? ((ph - 1) % 8 >= 4) : idle_hi;
  end
endmodule // acr_host_model

//--- acr_top_tb.sv
// Self-checking bench for the converter control and readout block.
module acr_top_tb
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cnv_n = 1'b1, pd = 1'b0;
  logic cs_n = 1'b0, rd_n = 1'b0, coding = 1'b1, spsel = 1'b0, swap = 1'b0, ext = 1'b0, rdc = 1'b0;
  logic go = 1'b0, idle_hi = 1'b0, inv = 1'b0, bz = 1'b0, ovr_seen = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv;
  logic avs_waitrequest, busy, data_oe, sclk_o, sclk_oe, sdo, sdo_oe, fvs, fv_oe, ovr, sclk_h, edge_err;
  logic [15:0] data_out, word, ex;
  logic [4:0] nbits;
  int n_errors = 0, check_count = 0, b = 0, nr = 0;

  always #12.5 clock = ~clock;

  acr_top dut (.clock, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .convert_start_n(cnv_n), .power_down_input(pd), .busy, .device_select_n(cs_n),
    .read_enable_n(rd_n), .output_coding_select(coding), .serial_parallel_select(spsel),
    .byte_order_swap(swap), .clock_source_select(ext), .read_mode_or_chain_input(rdc), .data_out,
    .data_oe, .serial_clock_in(sclk_h), .serial_clock_out(sclk_o), .serial_clock_oe(sclk_oe),
    .serial_data_out(sdo), .serial_data_oe(sdo_oe), .frame_valid_strobe(fvs), .frame_valid_oe(fv_oe),
    .read_overrun_flag(ovr));

  // A released data line shows the inverse of its last level, so stale bits cannot pass.
  acr_host_model host (.clock, .go, .idle_hi, .master(!ext), .inv, .sdo(sdo_oe ? sdo : ~sdo),
    .sclk_dev(sclk_o), .sync_dev(fv_oe ? fvs : inv), .sclk(sclk_h), .word, .nbits, .edge_err);

  // ----
  // Tasks
  // ----
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clock);
      ovr_seen |= (ovr === 1'b1);
      if (busy === 1'b1) b++;
      if (busy === 1'b1 && !bz) nr++;
      bz = (busy === 1'b1);
      @(posedge clock);
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) bail();
    tick(1);
  endtask

  task automatic conv(input logic poke);
    int i;
    cnv_n <= 1'b0;
    tick(3);
    cnv_n <= 1'b1;
    b = 0;
    for (i = 0; i < 400 && !(b > 0 && !bz); i++) begin
      tick(1);
      cnv_n <= !(poke && b == 5);
      pd <= poke && b == 5;
    end
    if (i == 400) bail();
  endtask

  task automatic host_go();
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
  endtask

  task automatic bail();
    n_errors++;
    tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    tick(6);
    reset_n <= 1'b1;
    tick(3);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rv, 32'h0);
    bus(1'b1, 4'h1, 32'hffff_ffff);
    bus(1'b0, 4'h1, 32'h0);
    chk(rv, 32'h0);
    bus(1'b1, ADDR_SAMPLE, 32'hdead_12c4);
    bus(1'b0, ADDR_SAMPLE, 32'h0);
    chk(rv, 32'h0000_12c4);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      coding <= k[0];
      swap <= k[1];
      conv(k == 0);
      tick(60);
      if (k == 0) chk(32'(b), 32'(CONV_CNT));
      ex = k[0] ? 16'h12c4 : 16'h92c4;
      chk(32'(data_out), 32'(k[1] ? {ex[7:0], ex[15:8]} : ex));
      chk(32'(data_oe), 32'h1);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk(rv, 32'(ex));
    end
    for (int k = 1; k < 4; k++) begin
      rd_n <= k[0];
      cs_n <= k[1];
      tick(6);
      chk(32'(data_oe), 32'h0);
    end
    rd_n <= 1'b0;
    cs_n <= 1'b0;
    $display("test parallel done");
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, ADDR_CTRL, 32'(r));
      cnv_n <= 1'b0;
      nr = 0;
      tick(300);
      chk(32'(nr > 1), 32'(r == 2));
      cnv_n <= 1'b1;
      tick(100);
    end
    bus(1'b1, ADDR_CTRL, 32'h0);
    $display("test rate modes done");
    spsel <= 1'b1;
    ext <= 1'b1;
    bus(1'b1, ADDR_SAMPLE, 32'ha5c3);
    for (int k = 0; k < 2; k++) begin
      cs_n <= 1'b1;
      idle_hi <= k[0];
      conv(1'b0);
      host_go();
      tick(140);
      cs_n <= 1'b0;
      tick(4);
      host_go();
      tick(140);
      chk(32'(word), 32'ha5c3);
      chk(32'(nbits), 32'h10);
      chk(32'(edge_err), 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rv, 32'h1 << STAT_ALL_READ);
    end
    rdc <= 1'b1;
    conv(1'b0);
    ovr_seen = 1'b0;
    conv(1'b0);
    chk(32'(ovr_seen), 32'h1);
    host_go();
    tick(140);
    ovr_seen = 1'b0;
    conv(1'b0);
    tick(4);
    chk(32'(ovr_seen), 32'h0);
    $display("test slave serial done");
    ext <= 1'b0;
    rdc <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_CTRL, k[0] ? 32'hc : 32'h0);
      inv <= k[0];
      host_go();
      conv(1'b0);
      tick(4);
      chk(32'(word), 32'ha5c3);
      chk(32'(nbits), 32'h10);
      chk(32'(b > CONV_CNT + 60), 32'h1);
    end
    rdc <= 1'b1;
    bus(1'b1, ADDR_SAMPLE, 32'h5a3c);
    host_go();
    conv(1'b0);
    chk(32'(b), 32'(CONV_CNT));
    tick(60);
    chk(32'(word), 32'ha5c3);
    $display("test master serial done");
    tally_and_finish();
  end
endmodule // acr_top_tb
